// [hw/irq_pkg.sv]
package irq_pkg;

    localparam int REG_ADDR_W  = 4;
    localparam int PC_W        = 13;
    localparam int STACK_DEPTH = 8;
    localparam int SP_W        = $clog2(STACK_DEPTH);
    localparam int PORT_B_PINS_W     = 8;

    // register offsets
    localparam logic [REG_ADDR_W-1:0] ADDR_CTRL   = 4'h0;
    localparam logic [REG_ADDR_W-1:0] ADDR_REQ_A  = 4'h1;
    localparam logic [REG_ADDR_W-1:0] ADDR_REQ_B  = 4'h2;
    localparam logic [REG_ADDR_W-1:0] ADDR_EN_A   = 4'h3;
    localparam logic [REG_ADDR_W-1:0] ADDR_EN_B   = 4'h4;
    localparam logic [REG_ADDR_W-1:0] ADDR_OPTION = 4'h5;
    localparam logic [REG_ADDR_W-1:0] ADDR_MASK   = 4'h6;
    localparam logic [REG_ADDR_W-1:0] ADDR_TIMER0 = 4'h7;
    localparam logic [REG_ADDR_W-1:0] ADDR_STATUS = 4'h8;
    localparam logic [REG_ADDR_W-1:0] ADDR_PORT_B_PINS  = 4'h9;

    // irq_control_reg fields
    localparam int CTRL_GLOBAL_EN = 7;
    localparam int CTRL_PEIE      = 6;
    localparam int CTRL_T0_EN     = 5;
    localparam int CTRL_EXT_EN    = 4;
    localparam int CTRL_PB_EN     = 3;
    localparam int CTRL_T0_FLAG   = 2;
    localparam int CTRL_EXT_FLAG  = 1;
    localparam int CTRL_PB_FLAG   = 0;

    // option register field
    localparam int OPT_EDGE = 0;

    // periph_request_reg_a: 0 timer1, 1 timer2, 2 capture_compare_a, 3 sync_serial_port,
    // 4 transmit, 5 receive, 6 a/d, 7 eeprom write
    // periph_request_reg_b: 0 capture_compare_b, 2 low_voltage_detect, 4 lcd,
    // 5 comparator 1, 6 comparator 2, 7 fail-safe clock monitor
    localparam logic [7:0] REQ_A_MASK = 8'hFF;
    localparam logic [7:0] REQ_B_MASK = 8'hF5;

    localparam logic [7:0]      CTRL_RESET   = 8'h00;
    localparam logic [7:0]      OPT_RESET    = 8'h01;
    localparam logic [7:0]      BYTE_ZERO    = 8'h00;
    localparam logic [7:0]      TIMER0_TOP   = 8'hFF;
    localparam logic [PC_W-1:0] IRQ_VECTOR   = 13'h0004;

    typedef enum logic [0:0] {ST_RUN, ST_SLEEP} run_state_t;

    typedef struct packed {
        logic [REG_ADDR_W-1:0] addr;
        logic [7:0]            wdata;
        logic                  wr;
        logic                  rd;
    } reg_req_t;

    typedef struct packed {
        logic            irq_request;
        logic            vector_load;
        logic [PC_W-1:0] vector_pc;
        logic            pop_valid;
        logic [PC_W-1:0] pop_pc;
        logic            wake_up;
        logic            sleeping;
    } core_out_t;

    typedef struct packed {
        logic [PORT_B_PINS_W-1:0] periph_a;
        logic [PORT_B_PINS_W-1:0] periph_b;
    } periph_evt_t;

endpackage

// [hw/pin_sync.sv]
`timescale 1ns/1ps
module pin_sync
    import irq_pkg::*;
#(
    parameter int WIDTH = 9
) (
    input  wire logic             ref_clk,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] pins_async,
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] held
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            // a change counts once the second and third stage agree
            always_comb begin
                level[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : held[i];
            end
            always_ff @(posedge ref_clk) begin
                if (srst) begin
                    // chain follows the pins so a level held through reset is no edge
                    s1_reg[i] <= pins_async[i];
                    s2_reg[i] <= s1_reg[i];
                    s3_reg[i] <= s2_reg[i];
                    held[i]   <= s2_reg[i];
                end else begin
                    s1_reg[i] <= pins_async[i];
                    s2_reg[i] <= s1_reg[i];
                    s3_reg[i] <= s2_reg[i];
                    held[i]   <= level[i];
                end
            end
        end
    endgenerate
endmodule // pin_sync

// [hw/timer0_counter.sv]
`timescale 1ns/1ps
module timer0_counter
    import irq_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       srst,
    input  wire logic       tick,
    input  wire logic       load,
    input  wire logic [7:0] load_value,
    output logic      [7:0] count,
    output logic            wrap
);
    logic [7:0] count_reg;
    logic [7:0] count_next;

    always_comb begin
        wrap       = tick && !load && (count_reg == TIMER0_TOP); // RULE_13
        count_next = count_reg;
        if (load) begin
            count_next = load_value;
        end else if (tick) begin
            count_next = 8'(count_reg + 8'h01);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            count_reg <= BYTE_ZERO;
        end else begin
            count_reg <= count_next;
        end
    end

    assign count = count_reg;
endmodule // timer0_counter

// [hw/irq_controller.sv]
// Behaviour
// RULE_01 - global enable set passes unmasked requests; cleared blocks every request
// RULE_02 - every reset clears the global enable
// RULE_03 - return-from-interrupt instruction pops the stack and sets the global enable
// RULE_04 - taking a request clears global enable, pushes return address, jumps to 0004h
// RULE_05 - pin and port-b events reach the vector in three or four cycles
// RULE_06 - flags set on their events whatever the enables are
// RULE_07 - requests in the cycle of a global-enable clear are ignored but stay pending
// RULE_08 - software polls flags and clears them before re-enabling; hardware never clears
// RULE_09 - external pin flag set on rising or falling edge per edge select
// RULE_10 - external enable cleared blocks the pin request but edges still set its flag
// RULE_11 - pin edge wakes from sleep only if its enable was set before sleep
// RULE_12 - after wake the vector is taken only with global enable set
// RULE_13 - timer0 wrap from FFh to 00h sets its flag, gated by its enable
// RULE_14 - masked port-b pin change sets the change flag, gated by its enable
// RULE_15 - a change coinciding with a port-b read may be lost
// RULE_16 - active lcd function on the pin disables the external interrupt
// RULE_17 - first peripheral request and enable registers hold eight sources
// RULE_18 - second peripheral request and enable registers hold six sources
// RULE_19 - control register holds three flags, their enables and global enable
// RULE_20 - request needs global enable and an unmasked flag; wake needs the flag only
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module irq_controller
    import irq_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH
) (
    input  wire logic               ref_clk,
    input  wire logic               srst,
    input  wire reg_req_t           reg_bus,
    output logic      [7:0]         rd_data,
    input  wire periph_evt_t        periph_evt,
    input  wire logic               ext_irq_pin,
    input  wire logic [PORT_B_PINS_W-1:0] port_b_pins,
    input  wire logic               lcd_seg_active,
    input  wire logic               timer0_tick,
    input  wire logic               return_from_irq_instr,
    input  wire logic               sleep_instr,
    input  wire logic [PC_W-1:0]    return_pc,
    output core_out_t               core_out
);
    localparam int SYNC_W = PORT_B_PINS_W + 1;

    typedef struct packed {
        run_state_t                     st;
        logic [7:0]                     ctrl;
        logic [7:0]                     req_a;
        logic [7:0]                     req_b;
        logic [7:0]                     en_a;
        logic [7:0]                     en_b;
        logic [7:0]                     option;
        logic [7:0]                     pin_mask;
        logic [PORT_B_PINS_W-1:0]             port_b_pins_latch;
        logic                           ext_en_at_sleep;
        logic [SP_W-1:0]                sp;
        logic [DEPTH-1:0][PC_W-1:0]     stack;
        logic [7:0]                     rd_data;
        core_out_t                      out;
    } state_t;

    state_t state_reg;
    state_t state_next;

    logic [SYNC_W-1:0] sync_level;
    logic [SYNC_W-1:0] sync_held;
    logic [7:0]        timer0_value;
    logic              timer0_wrap;
    logic              wr_ctrl;
    logic              rd_port_b_pins;
    logic              global_clear_now;
    logic              ext_rise;
    logic              ext_fall;
    logic              ext_edge;
    logic              port_b_pins_change;
    logic [7:0]        ctrl_flags;
    logic              unmasked_core;
    logic              unmasked_periph;
    logic              wake_cond;
    logic              take;

    pin_sync #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .ref_clk    (ref_clk),
        .srst       (srst),
        .pins_async ({port_b_pins, ext_irq_pin}),
        .level      (sync_level),
        .held       (sync_held)
    );

    timer0_counter u_timer0 (
        .ref_clk    (ref_clk),
        .srst       (srst),
        .tick       (timer0_tick),
        .load       (reg_bus.wr && (reg_bus.addr == ADDR_TIMER0)),
        .load_value (reg_bus.wdata),
        .count      (timer0_value),
        .wrap       (timer0_wrap)
    );

    always_comb begin
        state_next = state_reg;
        state_next.out.vector_load = 1'b0;
        state_next.out.pop_valid   = 1'b0;
        state_next.out.wake_up     = 1'b0;

        wr_ctrl       = reg_bus.wr && (reg_bus.addr == ADDR_CTRL);
        rd_port_b_pins      = reg_bus.rd && (reg_bus.addr == ADDR_PORT_B_PINS);
        global_clear_now = wr_ctrl && !reg_bus.wdata[CTRL_GLOBAL_EN];

        // external pin edge, suppressed while the pin drives the lcd
        ext_rise = sync_level[0] && !sync_held[0];
        ext_fall = !sync_level[0] && sync_held[0];
        ext_edge = !lcd_seg_active && // RULE_16
                   (state_reg.option[OPT_EDGE] ? ext_rise : ext_fall); // RULE_09

        // port-b mismatch against the value latched at the last read
        port_b_pins_change = |((sync_level[SYNC_W-1:1] ^ state_reg.port_b_pins_latch)
                         & state_reg.pin_mask); // RULE_14
        if (rd_port_b_pins) begin
            state_next.port_b_pins_latch = sync_level[SYNC_W-1:1]; // RULE_15
        end

        // software writes, hardware sets win over clears
        ctrl_flags = wr_ctrl ? reg_bus.wdata : state_reg.ctrl; // RULE_19
        if (ext_edge) begin
            ctrl_flags[CTRL_EXT_FLAG] = 1'b1; // RULE_06
        end
        if (timer0_wrap) begin
            ctrl_flags[CTRL_T0_FLAG] = 1'b1; // RULE_13
        end
        if (port_b_pins_change && !rd_port_b_pins) begin
            ctrl_flags[CTRL_PB_FLAG] = 1'b1; // RULE_15
        end
        state_next.ctrl = ctrl_flags;

        if (reg_bus.wr && (reg_bus.addr == ADDR_REQ_A)) begin
            state_next.req_a = reg_bus.wdata & REQ_A_MASK;
        end
        if (reg_bus.wr && (reg_bus.addr == ADDR_REQ_B)) begin
            state_next.req_b = reg_bus.wdata & REQ_B_MASK;
        end
        state_next.req_a = state_next.req_a | (periph_evt.periph_a & REQ_A_MASK); // RULE_17
        state_next.req_b = state_next.req_b | (periph_evt.periph_b & REQ_B_MASK); // RULE_18

        if (reg_bus.wr && (reg_bus.addr == ADDR_EN_A)) begin
            state_next.en_a = reg_bus.wdata & REQ_A_MASK; // RULE_17
        end
        if (reg_bus.wr && (reg_bus.addr == ADDR_EN_B)) begin
            state_next.en_b = reg_bus.wdata & REQ_B_MASK; // RULE_18
        end
        if (reg_bus.wr && (reg_bus.addr == ADDR_OPTION)) begin
            state_next.option = reg_bus.wdata;
        end
        if (reg_bus.wr && (reg_bus.addr == ADDR_MASK)) begin
            state_next.pin_mask = reg_bus.wdata;
        end

        // unmasked sources, seen on the flag values being written now
        unmasked_core =
            (state_next.ctrl[CTRL_EXT_FLAG] && state_next.ctrl[CTRL_EXT_EN] &&
             (state_reg.st == ST_RUN || state_reg.ext_en_at_sleep)) || // RULE_10 RULE_11
            (state_next.ctrl[CTRL_T0_FLAG] && state_next.ctrl[CTRL_T0_EN]) || // RULE_13
            (state_next.ctrl[CTRL_PB_FLAG] && state_next.ctrl[CTRL_PB_EN]); // RULE_14
        unmasked_periph = state_next.ctrl[CTRL_PEIE] &&
            (|(state_next.req_a & state_next.en_a) || |(state_next.req_b & state_next.en_b));
        wake_cond = unmasked_core || unmasked_periph; // RULE_20

        take = 1'b0;
        unique case (state_reg.st)
            ST_RUN: begin
                if (sleep_instr) begin
                    state_next.st              = ST_SLEEP;
                    state_next.ext_en_at_sleep = state_next.ctrl[CTRL_EXT_EN];
                end else if (return_from_irq_instr) begin
                    state_next.ctrl[CTRL_GLOBAL_EN] = 1'b1; // RULE_03
                    state_next.sp             = SP_W'(state_reg.sp - 1'b1);
                    state_next.out.pop_valid  = 1'b1;
                    state_next.out.pop_pc     = state_reg.stack[SP_W'(state_reg.sp - 1'b1)];
                end else begin
                    // a clearing write this cycle blocks the take; flags stay pending
                    take = state_reg.ctrl[CTRL_GLOBAL_EN] && !global_clear_now && // RULE_01 RULE_07
                           wake_cond; // RULE_05 RULE_08
                end
            end
            ST_SLEEP: begin
                if (wake_cond) begin
                    state_next.st          = ST_RUN; // RULE_11
                    state_next.out.wake_up = 1'b1; // RULE_12
                end
            end
        endcase

        if (take) begin
            state_next.ctrl[CTRL_GLOBAL_EN]  = 1'b0; // RULE_04
            state_next.stack[state_reg.sp]   = return_pc;
            state_next.sp                    = SP_W'(state_reg.sp + 1'b1);
            state_next.out.vector_load       = 1'b1;
            state_next.out.vector_pc         = IRQ_VECTOR;
        end

        state_next.out.irq_request = state_next.ctrl[CTRL_GLOBAL_EN] && wake_cond; // RULE_20
        state_next.out.sleeping    = (state_next.st == ST_SLEEP);

        state_next.rd_data = BYTE_ZERO;
        if (reg_bus.rd) begin
            unique case (reg_bus.addr)
                ADDR_CTRL:   state_next.rd_data = state_reg.ctrl;
                ADDR_REQ_A:  state_next.rd_data = state_reg.req_a;
                ADDR_REQ_B:  state_next.rd_data = state_reg.req_b;
                ADDR_EN_A:   state_next.rd_data = state_reg.en_a;
                ADDR_EN_B:   state_next.rd_data = state_reg.en_b;
                ADDR_OPTION: state_next.rd_data = state_reg.option;
                ADDR_MASK:   state_next.rd_data = state_reg.pin_mask;
                ADDR_TIMER0: state_next.rd_data = timer0_value;
                ADDR_STATUS: state_next.rd_data = 8'({state_reg.st == ST_SLEEP, state_reg.sp});
                ADDR_PORT_B_PINS:  state_next.rd_data = sync_held[SYNC_W-1:1];
                default:     state_next.rd_data = BYTE_ZERO;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_reg          <= '0;
            state_reg.st       <= ST_RUN;
            state_reg.ctrl     <= CTRL_RESET; // RULE_02
            state_reg.option   <= OPT_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rd_data  = state_reg.rd_data;
    assign core_out = state_reg.out;
endmodule // irq_controller

// [verif/irq_checker_asserts.sv]
`timescale 1ns/1ps
module irq_checker
    import irq_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH
) (
    input wire logic               ref_clk,
    input wire logic               srst,
    input wire reg_req_t           reg_bus,
    input wire logic [7:0]         rd_data,
    input wire periph_evt_t        periph_evt,
    input wire logic               ext_irq_pin,
    input wire logic [PORT_B_PINS_W-1:0] port_b_pins,
    input wire logic               lcd_seg_active,
    input wire logic               timer0_tick,
    input wire logic               return_from_irq_instr,
    input wire logic               sleep_instr,
    input wire logic [PC_W-1:0]    return_pc,
    input wire core_out_t          core_out
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);

    reset_clear_a: assert property (disable iff (1'b0) srst |=> core_out == '0)
        else $error("outputs not cleared by reset");
    vec_pulse_a: assert property (core_out.vector_load |=> !core_out.vector_load)
        else $error("vector pulse too long");
    vec_addr_a: assert property (core_out.vector_load |-> core_out.vector_pc == 13'h0004)
        else $error("wrong vector address");
    ret_pop_a: assert property (return_from_irq_instr |=> core_out.pop_valid)
        else $error("return did not pop");
    ret_first_a: assert property (return_from_irq_instr |=> !core_out.vector_load)
        else $error("take beat return");
    enable_clear_a: assert property (reg_bus.wr && reg_bus.addr == ADDR_CTRL &&
        !reg_bus.wdata[CTRL_GLOBAL_EN] |=> !core_out.vector_load)
        else $error("take in global enable clear cycle");
    wake_branch_a: assert property (core_out.wake_up && core_out.irq_request &&
        !reg_bus.wr && !return_from_irq_instr && !sleep_instr |=> core_out.vector_load)
        else $error("no branch after enabled wake");
    wake_stay_a: assert property (core_out.wake_up && !core_out.irq_request |=>
        !core_out.vector_load)
        else $error("branch after wake with global enable clear");
    rd_idle_a: assert property (!reg_bus.rd |=> rd_data == 8'h00)
        else $error("read data outside its cycle");
    wake_edge_a: assert property (core_out.wake_up |->
        $past(core_out.sleeping) && !core_out.sleeping)
        else $error("wake without sleep");
    sleep_enter_a: assert property (sleep_instr && !core_out.sleeping |=> core_out.sleeping)
        else $error("sleep not entered");
    asleep_novec_a: assert property (core_out.vector_load |-> !core_out.sleeping)
        else $error("vector while asleep");
endmodule // irq_checker

// [verif/core_model.sv]
`timescale 1ns/1ps
module core_model
    import irq_pkg::*;
(
    input  wire logic            ref_clk,
    input  wire logic            srst,
    input  wire logic [3:0]      ret_delay,
    input  wire logic            sleep_go,
    input  wire core_out_t       core_out,
    output logic                 return_from_irq_instr,
    output logic                 sleep_instr,
    output logic      [PC_W-1:0] return_pc
);
    logic [3:0] wait_reg;

    // zero delay means the routine never returns
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            return_pc             <= '0;
            wait_reg              <= '0;
            return_from_irq_instr <= 1'b0;
            sleep_instr           <= 1'b0;
        end else begin
            return_pc             <= core_out.vector_load ? IRQ_VECTOR : return_pc + 13'h0001;
            sleep_instr           <= sleep_go;
            return_from_irq_instr <= (wait_reg == 4'h1);
            if (core_out.vector_load)
                wait_reg <= ret_delay;
            else if (wait_reg != 4'h0)
                wait_reg <= wait_reg - 4'h1;
        end
    end
endmodule // core_model

// [verif/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    import irq_pkg::*;

    logic        ref_clk = 1'b0;
    logic        srst = 1'b1;
    reg_req_t    bus = '0;
    periph_evt_t pev = '0;
    logic        pin = 1'b0;
    logic [7:0]  pb = 8'h00;
    logic        lcd = 1'b0;
    logic        tick0 = 1'b0;
    logic [3:0]  ret_delay = 4'h0;
    logic        sleep_go = 1'b0;
    logic        ret_i;
    logic        slp_i;
    logic [12:0] pc_i;
    logic [7:0]  rdd;
    core_out_t   co;
    int          errors = 0;
    int          checked = 0;
    int          cycles = 0;
    int          vecs = 0;
    int          wakes = 0;
    int          v0;
    int          n;

    always #25 ref_clk = ~ref_clk;

    irq_controller uut (.ref_clk(ref_clk), .srst(srst), .reg_bus(bus), .rd_data(rdd),
        .periph_evt(pev), .ext_irq_pin(pin), .port_b_pins(pb), .lcd_seg_active(lcd),
        .timer0_tick(tick0), .return_from_irq_instr(ret_i), .sleep_instr(slp_i),
        .return_pc(pc_i), .core_out(co));
    core_model core (.ref_clk(ref_clk), .srst(srst), .ret_delay(ret_delay),
        .sleep_go(sleep_go), .core_out(co), .return_from_irq_instr(ret_i),
        .sleep_instr(slp_i), .return_pc(pc_i));

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        vecs   <= vecs + int'(co.vector_load === 1'b1);
        wakes  <= wakes + int'(co.wake_up === 1'b1);
        if (cycles == 3000) begin
            errors++;
            give_verdict();
        end
    end

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] got);
        checked++;
        if (got !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", nm, e, got);
        end
    endtask
    task automatic ticks(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus <= '0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus <= '0;
        #1 chk(nm, {8'h00, e}, {8'h00, rdd});
    endtask
    task automatic pulse(input logic [7:0] a, input logic [7:0] b, input logic t);
        @(posedge ref_clk);
        pev   <= '{periph_a: a, periph_b: b};
        tick0 <= t;
        @(posedge ref_clk);
        pev   <= '0;
        tick0 <= 1'b0;
    endtask
    task automatic pin_to(input logic p, input logic [7:0] b);
        @(posedge ref_clk);
        pin <= p;
        pb  <= b;
        ticks(6);
    endtask
    task automatic nap(input logic p);
        @(posedge ref_clk);
        sleep_go <= 1'b1;
        pin      <= 1'b0;
        @(posedge ref_clk);
        sleep_go <= 1'b0;
        ticks(3);
        chk("asleep", 16'h0001, {15'h0000, co.sleeping});
        pin_to(p, pb);
    endtask

    initial begin
        ticks(12);
        srst <= 1'b0;
        rd(ADDR_CTRL, 8'h00, "ctrl");
        rd(ADDR_OPTION, 8'h01, "option");
        rd(4'hF, 8'h00, "unmapped");
        pulse(8'hFF, 8'hFF, 1'b0);
        rd(ADDR_REQ_A, 8'hFF, "req_a");
        rd(ADDR_REQ_B, 8'hF5, "req_b");
        wr(ADDR_EN_B, 8'hFF);
        rd(ADDR_EN_B, 8'hF5, "en_b");
        wr(ADDR_REQ_A, 8'h00);
        wr(ADDR_REQ_B, 8'h00);
        wr(ADDR_EN_B, 8'h00);
        wr(ADDR_TIMER0, 8'hFF);
        pulse(8'h00, 8'h00, 1'b1);
        rd(ADDR_TIMER0, 8'h00, "timer0");
        rd(ADDR_CTRL, 8'h04, "wrap flag");
        wr(ADDR_CTRL, 8'h00);
        pin_to(1'b1, 8'h00);
        rd(ADDR_CTRL, 8'h02, "rise flag");
        wr(ADDR_OPTION, 8'h00);
        wr(ADDR_CTRL, 8'h00);
        pin_to(1'b0, 8'h00);
        rd(ADDR_CTRL, 8'h02, "fall flag");
        wr(ADDR_OPTION, 8'h01);
        wr(ADDR_CTRL, 8'h00);
        lcd <= 1'b1;
        pin_to(1'b1, 8'h00);
        rd(ADDR_CTRL, 8'h00, "lcd blocks");
        lcd <= 1'b0;
        pin_to(1'b0, 8'h00);
        rd(ADDR_CTRL, 8'h00, "wrong edge");
        wr(ADDR_MASK, 8'h04);
        rd(ADDR_PORT_B_PINS, 8'h00, "port_b_pins");
        pin_to(1'b0, 8'h01);
        rd(ADDR_CTRL, 8'h00, "unmasked pin");
        pin_to(1'b0, 8'h05);
        rd(ADDR_CTRL, 8'h01, "change flag");
        rd(ADDR_PORT_B_PINS, 8'h05, "port_b_pins");
        wr(ADDR_CTRL, 8'h00);
        rd(ADDR_CTRL, 8'h00, "relatched");
        chk("vectors", 16'h0000, 16'(vecs));
        wr(ADDR_CTRL, 8'h90);
        ret_delay <= 4'h3;
        @(posedge ref_clk);
        pin <= 1'b1;
        n = 0;
        do begin
            ticks(1);
            n++;
        end while (co.vector_load !== 1'b1 && n < 8);
        chk("latency", 16'h0001, 16'(n >= 3 && n <= 4));
        chk("vector pc", 16'h0004, 16'(co.vector_pc));
        ticks(24);
        chk("repeats", 16'h0001, 16'(vecs >= 3));
        chk("pop pc", 16'(IRQ_VECTOR + 13'h0004), 16'(co.pop_pc));
        ret_delay <= 4'h0;
        ticks(12);
        rd(ADDR_CTRL, 8'h12, "global off");
        wr(ADDR_CTRL, 8'h00);
        v0 = vecs;
        wr(ADDR_EN_A, 8'h01);
        pulse(8'h01, 8'h00, 1'b0);
        ticks(4);
        chk("held", 16'(v0), 16'(vecs));
        wr(ADDR_CTRL, 8'hC0);
        ticks(4);
        chk("pending", 16'(v0 + 1), 16'(vecs));
        wr(ADDR_REQ_A, 8'h00);
        wr(ADDR_CTRL, 8'h10);
        nap(1'b1);
        chk("woken", 16'h0001, 16'(wakes));
        chk("no branch", 16'(v0 + 1), 16'(vecs));
        wr(ADDR_CTRL, 8'h90);
        nap(1'b1);
        chk("branch", 16'(v0 + 2), 16'(vecs));
        wr(ADDR_CTRL, 8'h00);
        nap(1'b1);
        chk("stays asleep", 16'h0001, {15'h0000, co.sleeping});
        rd(ADDR_CTRL, 8'h02, "flag asleep");
        @(posedge ref_clk);
        srst <= 1'b1;
        ticks(2);
        srst <= 1'b0;
        rd(ADDR_CTRL, 8'h00, "ctrl");
        chk("awake", 16'h0000, {15'h0000, co.sleeping});
        give_verdict();
    end
endmodule // tb_top

bind irq_controller irq_checker #(.DEPTH(DEPTH)) chk_u (.ref_clk(ref_clk), .srst(srst),
    .reg_bus(reg_bus), .rd_data(rd_data), .periph_evt(periph_evt),
    .ext_irq_pin(ext_irq_pin), .port_b_pins(port_b_pins), .lcd_seg_active(lcd_seg_active),
    .timer0_tick(timer0_tick), .return_from_irq_instr(return_from_irq_instr),
    .sleep_instr(sleep_instr), .return_pc(return_pc), .core_out(core_out));
